// ---- logic/pcac_map.svh ----
/*
  Constants of the card access controller: bus map, register offsets, field
  positions, reset values and timing counts.
  Assumes inclusion by the main module only.
*/
`ifndef PCAC_MAP_SVH
`define PCAC_MAP_SVH

`define PCAC_BANK_LSB 28
`define PCAC_BANK_REGS 2'h0
`define PCAC_BANK_CARD 2'h3
`define PCAC_SPACE_LSB 26
`define PCAC_SPACE_ATTR 2'h2
`define PCAC_SPACE_IO 2'h3
`define PCAC_OFS_CTRL 8'h00
`define PCAC_OFS_CWAIT 8'h04
`define PCAC_OFS_AWAIT 8'h08
`define PCAC_OFS_IWAIT 8'h0C
`define PCAC_OFS_STATUS 8'h10
`define PCAC_CTRL_RESET 6'h18
`define PCAC_BIT_WAITEN 1
`define PCAC_BIT_BANKEN 2
`define PCAC_BIT_TYPE 3
`define PCAC_WAIT_RESET 8'hFC
`define PCAC_TAIL_CYCLES 3'h4
`define PCAC_SIZE_BYTE 3'h0
`define PCAC_SIZE_HALF 3'h1
`define PCAC_SIZE_WORD 3'h2

`endif

// ---- logic/pcac_pkg.sv ----
/*
  Types of the card access controller: card pin bundle and access states.
  Assumes the map header sits beside it.
*/
`default_nettype none
package pcac_pkg;
  typedef struct packed {
    logic [25:0] addr;
    logic [15:0] dout;
    logic dout_en;
    logic card_select_upper_n;
    logic card_select_lower_n;
    logic register_space_select_n;
    logic output_strobe_n;
    logic write_strobe_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
  } pcac_card_out_t;

  typedef enum logic [7:0] {
    PCAC_IDLE = 8'h01,
    PCAC_SETUP = 8'h02,
    PCAC_STROBE = 8'h04,
    PCAC_HELD = 8'h08,
    PCAC_TAIL = 8'h10,
    PCAC_HOLD = 8'h20,
    PCAC_ERR1 = 8'h40,
    PCAC_ERR2 = 8'h80
  } pcac_state_t;
endpackage : pcac_pkg
`default_nettype wire

// ---- logic/pcac_sync.sv ----
/*
  Three-stage synchroniser for a level from a pin.
  Assumes a level slow against the clock; output follows once stages two and
  three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module pcac_sync (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // level in and out
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic hold_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      hold_q <= 1'b1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      hold_q <= level;
    end
  end

  // agreed level goes out without a further flop so a wait count of
  // four plus the card's delay still catches the request
  assign level = (s2_q == s3_q) ? s3_q : hold_q;
endmodule : pcac_sync
`default_nettype wire

// ---- logic/pcac_top.sv ----
/*
  Card access controller: AHB-Lite slave with a register page and a card bank
  that drives a 16-bit card in memory or I/O mode.
  Assumes single-word AHB-Lite transfers and a card on the pin bundle.
*/
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pcac_map.svh"
module pcac_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // card pins
  output pcac_pkg::pcac_card_out_t card_out,
  input wire logic [15:0] card_din,
  input wire logic card_wait_request_n
);
  import pcac_pkg::*;

  pcac_state_t st_q;
  logic [5:0] ctrl_q;
  logic [7:0] cwait_q;
  logic [7:0] await_q;
  logic [7:0] iwait_q;
  logic [1:0] space_q;
  logic [2:0] size_q;
  logic [25:0] addr_q;
  logic write_q;
  logic sub_q;
  logic two_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [7:0] cnt_q;
  logic reg_wr_q;
  logic [7:0] reg_ofs_q;
  logic [25:0] caddr_q;
  logic [15:0] cdout_q;
  logic wait_seen_q;
  logic wait_lvl;

  // request decode in the address phase
  logic take;
  logic card_hit;
  logic reg_hit;
  logic [1:0] a_space;
  logic a_io_byte;
  assign take = hsel && htrans[1] && hready;
  assign card_hit = take && (haddr[`PCAC_BANK_LSB +: 2] == `PCAC_BANK_CARD);
  assign reg_hit = take && (haddr[`PCAC_BANK_LSB +: 2] == `PCAC_BANK_REGS);
  assign a_space = haddr[`PCAC_SPACE_LSB +: 2];
  assign a_io_byte = (a_space == `PCAC_SPACE_IO) && (hsize == `PCAC_SIZE_BYTE);

  // per-transfer shape
  logic is_attr;
  logic is_io;
  logic is_word;
  logic wide;
  logic slot;
  logic a0;
  logic [7:0] wait_cycles;
  assign is_attr = (space_q == `PCAC_SPACE_ATTR);
  assign is_io = (space_q == `PCAC_SPACE_IO);
  assign is_word = (size_q == `PCAC_SIZE_WORD);
  assign wide = !is_attr && (size_q != `PCAC_SIZE_BYTE);
  assign slot = is_word ? sub_q : addr_q[1];
  assign a0 = (size_q == `PCAC_SIZE_BYTE) ? addr_q[0] : 1'b0;
  assign wait_cycles = is_io ? iwait_q : (is_attr ? await_q : cwait_q);

  logic [7:0] wbyte;
  always_comb begin
    wbyte = wdata_q[7:0];
    if (size_q == `PCAC_SIZE_BYTE) begin
      wbyte = wdata_q[{addr_q[1:0], 3'h0} +: 8];
    end else begin
      wbyte = wdata_q[{slot, 4'h0} +: 8];
    end
  end

  // wait request enters through three stages
  pcac_sync u_wait_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(card_wait_request_n),
    .level(wait_lvl)
  );

  logic wait_on;
  assign wait_on = ctrl_q[`PCAC_BIT_WAITEN] && !wait_lvl;

  // access sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= PCAC_IDLE;
      cnt_q <= 8'h00;
      sub_q <= 1'b0;
    end else begin
      unique case (st_q)
        PCAC_IDLE: begin
          sub_q <= 1'b0;
          if (card_hit && !ctrl_q[`PCAC_BIT_BANKEN]) begin
            st_q <= PCAC_ERR1;
          end else if (card_hit && !a_io_byte) begin
            st_q <= PCAC_SETUP;
          end
        end
        PCAC_SETUP: begin
          st_q <= PCAC_STROBE;
          cnt_q <= (wait_cycles == 8'h00) ? 8'h01 : wait_cycles;
        end
        PCAC_STROBE: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q <= wait_on ? PCAC_HELD : PCAC_HOLD;
          end
        end
        PCAC_HELD: begin
          if (!wait_on) begin
            st_q <= PCAC_TAIL;
            cnt_q <= {5'h00, `PCAC_TAIL_CYCLES};
          end
        end
        PCAC_TAIL: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q <= PCAC_HOLD;
          end
        end
        PCAC_HOLD: begin
          if (two_q && !sub_q) begin
            sub_q <= 1'b1;
            st_q <= PCAC_SETUP;
          end else begin
            st_q <= PCAC_IDLE;
          end
        end
        PCAC_ERR1: st_q <= PCAC_ERR2;
        PCAC_ERR2: st_q <= PCAC_IDLE;
      endcase
    end
  end

  // request capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      space_q <= 2'h0;
      size_q <= 3'h0;
      addr_q <= 26'h0000000;
      write_q <= 1'b0;
      two_q <= 1'b0;
    end else if (st_q == PCAC_IDLE && card_hit) begin
      space_q <= a_space;
      size_q <= hsize;
      addr_q <= haddr[25:0];
      write_q <= hwrite;
      two_q <= (hsize == `PCAC_SIZE_WORD);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdata_q <= 32'h00000000;
    end else if (st_q == PCAC_SETUP && !sub_q) begin
      wdata_q <= hwdata;
    end
  end

  // card address and write data, set in the setup cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      caddr_q <= 26'h0000000;
      cdout_q <= 16'h0000;
    end else if (st_q == PCAC_SETUP) begin
      caddr_q <= {addr_q[25:2], slot, a0};
      if (!sub_q) begin
        cdout_q <= wide ? hwdata[{slot, 4'h0} +: 16] : {8'h00, (size_q == `PCAC_SIZE_BYTE) ?
          hwdata[{addr_q[1:0], 3'h0} +: 8] : hwdata[{slot, 4'h0} +: 8]};
      end else begin
        cdout_q <= wide ? wdata_q[{slot, 4'h0} +: 16] : {8'h00, wbyte};
      end
    end
  end

  // read data gathering and register reads
  logic strobe_end;
  assign strobe_end = (st_q == PCAC_STROBE && cnt_q == 8'h01 && !wait_on) ||
    (st_q == PCAC_TAIL && cnt_q == 8'h01);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (st_q == PCAC_IDLE && take) begin
      rdata_q <= 32'h00000000;
      if (reg_hit && !hwrite) begin
        unique case (haddr[7:0])
          `PCAC_OFS_CTRL: rdata_q <= {26'h0000000, ctrl_q};
          `PCAC_OFS_CWAIT: rdata_q <= {24'h000000, cwait_q};
          `PCAC_OFS_AWAIT: rdata_q <= {24'h000000, await_q};
          `PCAC_OFS_IWAIT: rdata_q <= {24'h000000, iwait_q};
          `PCAC_OFS_STATUS: rdata_q <= {30'h00000000, wait_seen_q, wait_lvl};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end else if (strobe_end && !write_q) begin
      if (wide) begin
        rdata_q[{slot, 4'h0} +: 16] <= card_din;
      end else if (size_q == `PCAC_SIZE_BYTE) begin
        rdata_q[{addr_q[1:0], 3'h0} +: 8] <= card_din[7:0];
      end else begin
        rdata_q[{slot, 4'h0} +: 16] <= {8'h00, card_din[7:0]};
      end
    end
  end

  // register writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_wr_q <= 1'b0;
      reg_ofs_q <= 8'h00;
    end else begin
      reg_wr_q <= (st_q == PCAC_IDLE) && reg_hit && hwrite;
      reg_ofs_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `PCAC_CTRL_RESET;
      cwait_q <= `PCAC_WAIT_RESET;
      await_q <= `PCAC_WAIT_RESET;
      iwait_q <= `PCAC_WAIT_RESET;
    end else if (reg_wr_q) begin
      unique case (reg_ofs_q)
        `PCAC_OFS_CTRL: ctrl_q <= {hwdata[5:1], 1'b0};
        `PCAC_OFS_CWAIT: cwait_q <= hwdata[7:0];
        `PCAC_OFS_AWAIT: await_q <= hwdata[7:0];
        `PCAC_OFS_IWAIT: iwait_q <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // sticky: card held an access; set wins over a status write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_seen_q <= 1'b0;
    end else if (st_q == PCAC_HELD) begin
      wait_seen_q <= 1'b1;
    end else if (reg_wr_q && reg_ofs_q == `PCAC_OFS_STATUS && hwdata[1]) begin
      wait_seen_q <= 1'b0;
    end
  end

  // bus answer
  assign hreadyout = (st_q == PCAC_IDLE) || (st_q == PCAC_ERR2);
  assign hresp = (st_q == PCAC_ERR1) || (st_q == PCAC_ERR2);
  assign hrdata = rdata_q;

  // card pins
  logic active;
  logic strobe;
  assign active = !(st_q inside {PCAC_IDLE, PCAC_ERR1, PCAC_ERR2});
  assign strobe = st_q inside {PCAC_STROBE, PCAC_HELD, PCAC_TAIL};
  always_comb begin
    card_out.addr = caddr_q;
    card_out.dout = cdout_q;
    card_out.dout_en = active && write_q;
    card_out.card_select_upper_n = !(active && wide);
    card_out.card_select_lower_n = !active;
    card_out.register_space_select_n = !(active && (is_attr || is_io));
    card_out.output_strobe_n = !(strobe && !is_io && !write_q);
    card_out.write_strobe_n = !(strobe && !is_io && write_q);
    card_out.io_read_strobe_n = !(strobe && is_io && !write_q);
    card_out.io_write_strobe_n = !(strobe && is_io && write_q);
  end

  // checks
  logic mem_strobe;
  assign mem_strobe = !card_out.output_strobe_n || !card_out.write_strobe_n;
  logic any_strobe;
  assign any_strobe = mem_strobe || !card_out.io_read_strobe_n || !card_out.io_write_strobe_n;

  sequence tail_run_s;
    (st_q == PCAC_TAIL) [*4] ##1 (st_q == PCAC_HOLD);
  endsequence

  odd_byte_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (strobe && !is_io && size_q == `PCAC_SIZE_BYTE) |-> card_out.card_select_upper_n)
    else $error("upper select driven on byte access");
  word_both_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (strobe && !is_attr && size_q != `PCAC_SIZE_BYTE) |->
    (!card_out.card_select_upper_n && !card_out.card_select_lower_n))
    else $error("word access without both selects");
  attr_lane_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mem_strobe && is_attr) |-> (card_out.card_select_upper_n &&
    !card_out.register_space_select_n && !card_out.addr[0] || size_q == `PCAC_SIZE_BYTE))
    else $error("attribute access on wrong lane");
  common_reg_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mem_strobe && !is_attr) |-> card_out.register_space_select_n)
    else $error("register select low in common memory");
  io_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (strobe && is_io) |-> (!mem_strobe && !card_out.register_space_select_n))
    else $error("io access with memory strobe");
  tail_four_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == PCAC_HELD && !wait_on) |=> tail_run_s)
    else $error("wait tail not four cycles");
  disabled_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == PCAC_IDLE && card_hit && !ctrl_q[`PCAC_BIT_BANKEN]) |=>
    (hresp && !hreadyout) ##1 (hresp && hreadyout))
    else $error("disabled bank not answered with error");
  no_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_q[`PCAC_BIT_WAITEN] |-> (st_q != PCAC_HELD))
    else $error("wait honoured while disabled");
  two_xfer_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == PCAC_HOLD && two_q && !sub_q) |=> (st_q == PCAC_SETUP && sub_q))
    else $error("second half of word access missing");
  sync_use_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(wait_lvl) |-> $past(card_wait_request_n, 3) == 1'b0)
    else $error("wait level not synchronised");
  wait_held_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == PCAC_STROBE && cnt_q == 8'h01 && wait_on) |=> (st_q == PCAC_HELD && any_strobe))
    else $error("wait request not honoured");
  card_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == PCAC_IDLE && card_hit && ctrl_q[`PCAC_BIT_BANKEN] && !a_io_byte) |=>
    (!hreadyout && !card_out.card_select_lower_n))
    else $error("card access not started");
  io_byte_skip_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == PCAC_IDLE && card_hit && ctrl_q[`PCAC_BIT_BANKEN] && a_io_byte) |=>
    (hreadyout && !hresp && card_out.card_select_lower_n))
    else $error("unsupported io byte not completed");
  lower_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    any_strobe |-> !card_out.card_select_lower_n)
    else $error("strobe without card select");
  attr_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (strobe && is_attr) |-> (card_out.addr[9] == addr_q[9]))
    else $error("attribute line 9 not carried");
endmodule : pcac_top
`default_nettype wire

// ---- verif/pcac_card_model.sv ----
/*
  16-bit card model in memory and i/o mode, one store shared by all spaces.
  Assumes the controller pin bundle and the bus clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pcac_card_model (
  // clock
  input wire logic hclk,
  // card pins
  input wire pcac_pkg::pcac_card_out_t card_out,
  output logic [15:0] card_din,
  output logic card_wait_request_n,
  // wait cycles to request per strobe
  input wire logic [7:0] stall_len
);
  import pcac_pkg::*;
  logic [15:0] mem [256];
  logic [7:0] wcnt;
  logic act_q;
  logic rd;
  logic wr;
  logic up;
  logic lo;
  logic [7:0] i;
  assign up = !card_out.card_select_upper_n;
  assign lo = !card_out.card_select_lower_n;
  assign rd = !card_out.output_strobe_n || !card_out.io_read_strobe_n;
  assign wr = !card_out.write_strobe_n || !card_out.io_write_strobe_n;
  assign i = card_out.addr[8:1];
  // wait goes low two cycles after the strobe starts, for stall_len cycles
  assign card_wait_request_n = !(wcnt != 8'h00 && wcnt <= stall_len);
  initial begin
    card_din = 16'h0000;
    wcnt = 8'h00;
    act_q = 1'b0;
  end
  always @(posedge hclk) begin
    act_q <= rd || wr;
    if (wr && up) mem[i][15:8] <= card_out.dout[15:8];
    if (wr && lo && card_out.addr[0]) mem[i][15:8] <= card_out.dout[7:0];
    if (wr && lo && !card_out.addr[0]) mem[i][7:0] <= card_out.dout[7:0];
    if ((rd || wr) && !act_q && stall_len != 8'h00) wcnt <= stall_len + 8'h01;
    else if (wcnt != 8'h00) wcnt <= wcnt - 8'h01;
  end
  // read data settles mid-cycle, so a one-cycle strobe already sees it
  always @(negedge hclk) begin
    // lanes not read show the inverse of their last value
    card_din <= ~card_din;
    if (rd && up) card_din[15:8] <= mem[i][15:8];
    if (rd && lo) card_din[7:0] <= card_out.addr[0] ? mem[i][15:8] : mem[i][7:0];
  end
endmodule : pcac_card_model
`default_nettype wire

// ---- verif/pcac_top_tb.sv ----
/*
  Self-checking bench: ahb-lite master, response and pin monitors, card model.
  Assumes the controller top and the card model.
*/
`timescale 1ns/1ps
`default_nettype none
module pcac_top_tb;
  import pcac_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic r;} pcac_note_t;
  logic hclk, hresetn, hsel, hwrite, hresp, hready, wait_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] din;
  logic [7:0] stall;
  logic [8:0] pins;
  logic [31:0] v [5];
  pcac_card_out_t co;
  pcac_note_t bus_q [$];
  logic [8:0] pin_q [$];
  int err_count, num_checks, cyc, slen, scnt;
  logic dp;
  pcac_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .card_out(co), .card_din(din),
    .card_wait_request_n(wait_n));
  pcac_card_model u_card (.hclk(hclk), .card_out(co), .card_din(din),
    .card_wait_request_n(wait_n), .stall_len(stall));
  assign pins = {co.addr[9], co.addr[0], co.card_select_upper_n, co.card_select_lower_n,
    co.register_space_select_n, co.output_strobe_n, co.write_strobe_n, co.io_read_strobe_n,
    co.io_write_strobe_n};
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic chk_pins(input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD card_pins expected %h seen %h", e, g);
    end
  endtask : chk_pins
  task automatic end_sim;
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // one transfer; notes the bus result and n card cycles with pin pattern p
  task automatic acc(input logic wr, input logic [31:0] a, input logic [2:0] sz,
      input logic [31:0] wd, input logic [31:0] e, input logic [31:0] m, input logic r,
      input logic [8:0] p, input int n);
    bus_q.push_back('{e, m, r});
    repeat (n) pin_q.push_back(p);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : acc
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
    if (dp && hready && bus_q.size() > 0) begin
      chk_word("hrdata", bus_q[0].d & bus_q[0].m, hrdata & bus_q[0].m);
      chk_word("hresp", {31'h0, bus_q[0].r}, {31'h0, hresp});
      void'(bus_q.pop_front());
    end
    if (hready) dp = hsel && htrans[1];
    if (!(co.output_strobe_n && co.write_strobe_n &&
        co.io_read_strobe_n && co.io_write_strobe_n)) begin
      if (scnt == 0) chk_pins(pin_q.size() > 0 ? pin_q.pop_front() : 9'h1FF, pins);
      scnt++;
    end else if (scnt != 0) begin
      slen = scnt;
      scnt = 0;
    end
  end
  initial begin
    {hresetn, hsel, hwrite, dp} = 4'h0;
    {haddr, hwdata, htrans, hsize, stall} = '0;
    {err_count, num_checks, cyc, slen, scnt} = '0;
    v[0] = $urandom(32'h47db);
    foreach (v[k]) v[k] = $urandom;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    acc(0, 32'h0, 3'h2, 0, 32'h18, '1, 0, 0, 0);
    for (int k = 1; k < 4; k++) acc(0, 32'(k * 4), 3'h2, 0, 32'hFC, '1, 0, 0, 0);
    acc(0, 32'h20, 3'h2, 0, 32'h0, '1, 0, 0, 0);
    acc(0, 32'h3000_0004, 3'h1, 0, 0, 0, 1, 0, 0);
    acc(1, 32'h0, 3'h2, 32'h14, 0, 0, 0, 0, 0);
    acc(0, 32'h0, 3'h2, 0, 32'h14, '1, 0, 0, 0);
    for (int k = 1; k < 4; k++) acc(1, 32'(k * 4), 3'h2, 32'(($urandom % 4) + 1), 0, 0, 0, 0, 0);
    acc(1, 32'h3000_0004, 3'h1, v[0], 0, 0, 0, 9'h01B, 1);
    acc(0, 32'h3000_0004, 3'h1, 0, v[0], 32'hFFFF, 0, 9'h017, 1);
    acc(1, 32'h3000_0008, 3'h2, v[1], 0, 0, 0, 9'h01B, 2);
    acc(0, 32'h3000_0008, 3'h2, 0, v[1], '1, 0, 9'h017, 2);
    acc(1, 32'h3000_0020, 3'h0, v[2], 0, 0, 0, 9'h05B, 1);
    acc(0, 32'h3000_0020, 3'h0, 0, v[2], 32'hFF, 0, 9'h057, 1);
    acc(1, 32'h3000_0021, 3'h0, v[2], 0, 0, 0, 9'h0DB, 1);
    acc(1, 32'h3800_0010, 3'h1, v[3], 0, 0, 0, 9'h04B, 1);
    acc(0, 32'h3800_0010, 3'h1, 0, v[3], 32'hFF, 0, 9'h047, 1);
    acc(1, 32'h3800_0240, 3'h2, v[4], 0, 0, 0, 9'h14B, 2);
    acc(0, 32'h3800_0240, 3'h0, 0, v[4], 32'hFF, 0, 9'h147, 1);
    acc(1, 32'h3C00_0030, 3'h1, v[1], 0, 0, 0, 9'h00E, 1);
    acc(0, 32'h3C00_0030, 3'h1, 0, v[1], 32'hFFFF, 0, 9'h00D, 1);
    acc(0, 32'h3C00_0031, 3'h0, 0, 0, 32'hFF, 0, 0, 0);
    acc(1, 32'h0, 3'h2, 32'h16, 0, 0, 0, 0, 0);
    acc(1, 32'h4, 3'h2, 32'h6, 0, 0, 0, 0, 0);
    stall <= 8'h05;
    acc(0, 32'h3000_0004, 3'h1, 0, v[0], 32'hFFFF, 0, 9'h017, 1);
    chk_word("strobe_len", 1, 32'(slen >= 10 && slen <= 15));
    acc(0, 32'h10, 3'h2, 0, 32'h3, '1, 0, 0, 0);
    acc(1, 32'h10, 3'h2, 32'h2, 0, 0, 0, 0, 0);
    acc(0, 32'h10, 3'h2, 0, 32'h1, '1, 0, 0, 0);
    acc(1, 32'h0, 3'h2, 32'h14, 0, 0, 0, 0, 0);
    acc(0, 32'h3000_0004, 3'h1, 0, v[0], 32'hFFFF, 0, 9'h017, 1);
    chk_word("strobe_len", 6, 32'(slen));
    repeat (2) @(posedge hclk);
    end_sim();
  end
endmodule : pcac_top_tb
`default_nettype wire
